// *** src/ibi_map.svh ***
// Constants of the instrument bus interface: bus commands, record
// characters, the status request bit position and timing counts.
// Assumes inclusion by the package and the modules of this block.
`ifndef IBI_MAP_SVH
`define IBI_MAP_SVH

// Addressed commands (low five bits masked off, group in bits 6:5).
`define IBI_GRP_LISTEN 2'h1
`define IBI_GRP_TALK 2'h2
`define IBI_GRP_CMD 2'h0
// Universal and addressed command codes.
`define IBI_CMD_GTL 8'h01
`define IBI_CMD_SDC 8'h04
`define IBI_CMD_GET 8'h08
`define IBI_CMD_LLO 8'h11
`define IBI_CMD_DCL 8'h14
`define IBI_CMD_SPE 8'h18
`define IBI_CMD_SPD 8'h19
`define IBI_ADDR_UNADDR 5'h1F
// Record characters.
`define IBI_CHAR_CR 8'h0D
`define IBI_CHAR_LF 8'h0A
// Trigger pulse length and clock rate.
`define IBI_CLK_HZ 50000000
`define IBI_TRIG_NS 1000
`define IBI_TRIG_CYC ((`IBI_TRIG_NS * (`IBI_CLK_HZ / 1000000) + 999) / 1000)
// Settling time for the data lines before DAV is asserted.
`define IBI_SETTLE_NS 100
`define IBI_SETTLE_CYC ((`IBI_SETTLE_NS * (`IBI_CLK_HZ / 1000000) + 999) / 1000)
// Status byte service request bit.
`define IBI_STB_RQS 6

`endif

// *** src/ibi_pkg.sv ***
// Types of the instrument bus interface.
// Assumes the map header is on the include path.
`include "ibi_map.svh"
package ibi_pkg;
    // Source handshake states.
    typedef enum logic [1:0] {SrcIdle, SrcSettle, SrcValid, SrcWait} ibi_src_t;
    // Acceptor handshake states.
    typedef enum logic [1:0] {AccReady, AccHold, AccDone} ibi_acc_t;
endpackage : ibi_pkg

// *** src/ibi_sync.sv ***
// Three-stage synchroniser with a filtered output register for a group of bus pin inputs.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/1ns
module ibi_sync #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] syncOut
);
    // Stage registers; the first is read by the second only.
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] out_d;

    // A change counts once the second and third stages agree.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
        end
    end

    // Register the stages; reset level is high (bus lines idle high).
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            out_q <= '1;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign syncOut = out_q;
endmodule : ibi_sync

// *** src/ibi_device.sv ***
// Device end of the instrument bus: handshakes, talker, listener,
// serial poll, service request, remote/local, clear and trigger.
// Assumes active-low bus lines given as level pins (low = true); outputs
// are open-drain style with an enable high while pulling low.
`timescale 1ns/1ns
module ibi_device
    import ibi_pkg::*;
#(
    parameter int TRIG_CYC = `IBI_TRIG_CYC,
    parameter int SETTLE_CYC = `IBI_SETTLE_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    // Bus pins, true when low.
    input wire logic [7:0] dioIn,
    output logic [7:0] dioOe,
    input wire logic davIn,
    output logic davOe,
    input wire logic nrfdIn,
    output logic nrfdOe,
    input wire logic ndacIn,
    output logic ndacOe,
    input wire logic atnIn,
    input wire logic ifcIn,
    input wire logic renIn,
    input wire logic eoiIn,
    output logic eoiOe,
    output logic srqOe,
    // Straps: address, listen-only, talk-only.
    input wire logic [4:0] myAddr,
    input wire logic listenOnly,
    input wire logic talkOnly,
    // Service request and status byte from the instrument.
    input wire logic svcReq,
    input wire logic [7:0] statusByte,
    // Talk stream from the instrument.
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    // Listen stream to the instrument.
    output logic [7:0] rxData,
    output logic rxValid,
    output logic rxEnd,
    // Instrument events.
    output logic devClear,
    output logic trigOut,
    output logic remote,
    output logic lockout
);
    // Synchronised bus lines (true = asserted); pins pass at pin level so
    // the idle-high reset of the synchroniser shows a quiet bus.
    logic [13:0] rawPins, syncPins;
    logic [7:0] dio;
    logic dav, nrfd, ndac, atn, ifc, ren;
    assign rawPins = {dioIn, davIn, nrfdIn, ndacIn, atnIn, ifcIn, renIn};
    assign {dio, dav, nrfd, ndac, atn, ifc, ren} = ~syncPins;

    ibi_sync #(.W(14)) uSync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .pinIn(rawPins),
        .syncOut(syncPins)
    );

    // State registers.
    ibi_src_t src_q, src_d;
    ibi_acc_t acc_q, acc_d;
    logic tads_q, tads_d, lads_q, lads_d, spms_q, spms_d;
    logic rem_q, rem_d, llo_q, llo_d, rqs_q, rqs_d;
    logic [7:0] dout_q, dout_d;
    logic eoi_q, eoi_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] trig_q, trig_d;
    logic clr_q, clr_d, txr_q, txr_d;
    logic [7:0] rxd_q, rxd_d;
    logic rxv_q, rxv_d, rxe_q, rxe_d;
    logic srqSent_q, srqSent_d;

    // Effective modes; talk-only wins when both straps are on.
    logic tonMode, lonMode, talkAct, lisAct;
    assign tonMode = talkOnly;
    assign lonMode = listenOnly && !talkOnly;
    assign talkAct = (tads_q || tonMode) && !atn;
    assign lisAct = (lads_q || lonMode) && !atn;

    // Next-state logic for all interface functions.
    always_comb begin
        logic take;
        logic [7:0] cmd;
        take = 1'b0;
        cmd = dio;
        src_d = src_q;
        acc_d = acc_q;
        tads_d = tads_q;
        lads_d = lads_q;
        spms_d = spms_q;
        rem_d = rem_q;
        llo_d = llo_q;
        rqs_d = rqs_q;
        dout_d = dout_q;
        eoi_d = 1'b0;
        cnt_d = cnt_q;
        trig_d = (trig_q != 16'h0000) ? trig_q - 16'h0001 : trig_q;
        clr_d = 1'b0;
        txr_d = 1'b0;
        rxd_d = rxd_q;
        rxv_d = 1'b0;
        rxe_d = 1'b0;
        srqSent_d = srqSent_q;
        // Service request is raised on a new request edge.
        if (svcReq && !srqSent_q && !tonMode && !lonMode) begin
            rqs_d = 1'b1;
            srqSent_d = 1'b1;
        end
        if (!svcReq) begin
            srqSent_d = 1'b0;
        end
        // Acceptor handshake for commands and listen data.
        case (acc_q)
            AccReady: begin
                if (dav && (atn || lisAct)) begin
                    take = 1'b1;
                    acc_d = AccHold;
                end
            end
            AccHold: begin
                acc_d = AccDone;
            end
            AccDone: begin
                if (!dav) begin
                    acc_d = AccReady;
                end
            end
            default: acc_d = AccReady;
        endcase
        // Decode one accepted byte as a bus command.
        if (take && atn) begin
            if (cmd[6:5] == `IBI_GRP_LISTEN) begin
                if (cmd[4:0] == `IBI_ADDR_UNADDR) begin
                    lads_d = 1'b0;
                end else if (cmd[4:0] == myAddr) begin
                    lads_d = 1'b1;
                    rem_d = ren;
                end
            end else if (cmd[6:5] == `IBI_GRP_TALK) begin
                if (cmd[4:0] == myAddr) begin
                    tads_d = 1'b1;
                    lads_d = 1'b0;
                end else begin
                    tads_d = 1'b0;
                end
            end else if (cmd == `IBI_CMD_DCL ||
                         (cmd == `IBI_CMD_SDC && lads_q)) begin
                clr_d = 1'b1;
            end else if (cmd == `IBI_CMD_GET && lads_q) begin
                trig_d = 16'(TRIG_CYC);
            end else if (cmd == `IBI_CMD_SPE) begin
                spms_d = 1'b1;
            end else if (cmd == `IBI_CMD_SPD) begin
                spms_d = 1'b0;
            end else if (cmd == `IBI_CMD_LLO) begin
                llo_d = 1'b1;
            end else if (cmd == `IBI_CMD_GTL && lads_q) begin
                rem_d = 1'b0;
            end
        end else if (take) begin
            // Listen data; a CR closes the record, LF is passed.
            rxd_d = dio;
            rxv_d = 1'b1;
            rxe_d = (dio == `IBI_CHAR_CR);
        end
        // Source handshake for talk data and the status byte.
        case (src_q)
            SrcIdle: begin
                if (talkAct && spms_q) begin
                    dout_d = statusByte;
                    dout_d[`IBI_STB_RQS] = rqs_q;
                    cnt_d = 16'(SETTLE_CYC);
                    src_d = SrcSettle;
                end else if (talkAct && txValid) begin
                    // The byte stays offered until the bus takes it.
                    dout_d = txData;
                    cnt_d = 16'(SETTLE_CYC);
                    src_d = SrcSettle;
                end
            end
            SrcSettle: begin
                if (cnt_q != 16'h0000) begin
                    cnt_d = cnt_q - 16'h0001;
                end else if (!nrfd) begin
                    src_d = SrcValid;
                end
            end
            SrcValid: begin
                if (!ndac) begin
                    // A new request in this very cycle outlives the poll.
                    if (spms_q) begin
                        if (srqSent_q || !svcReq) begin
                            rqs_d = 1'b0;
                        end
                    end else begin
                        // An aborted byte is never handed back.
                        txr_d = 1'b1;
                    end
                    src_d = SrcWait;
                end
            end
            SrcWait: begin
                src_d = SrcIdle;
            end
            default: src_d = SrcIdle;
        endcase
        // Losing talk or an attention abandons the byte on the lines.
        if (!talkAct && src_q != SrcIdle) begin
            src_d = SrcIdle;
        end
        // Remote enable false drops remote and lockout.
        if (!ren) begin
            rem_d = 1'b0;
            llo_d = 1'b0;
        end
        // Interface clear idles talker, addressed listener and serial poll.
        if (ifc) begin
            tads_d = 1'b0;
            lads_d = 1'b0;
            spms_d = 1'b0;
            src_d = SrcIdle;
        end
        // Only-modes force the other function idle.
        if (tonMode) begin
            lads_d = 1'b0;
            rqs_d = 1'b0;
        end
        if (lonMode) begin
            tads_d = 1'b0;
            rqs_d = 1'b0;
        end
    end

    // Register all interface state.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            src_q <= SrcIdle;
            acc_q <= AccReady;
            tads_q <= 1'b0;
            lads_q <= 1'b0;
            spms_q <= 1'b0;
            rem_q <= 1'b0;
            llo_q <= 1'b0;
            rqs_q <= 1'b0;
            dout_q <= 8'h00;
            eoi_q <= 1'b0;
            cnt_q <= 16'h0000;
            trig_q <= 16'h0000;
            clr_q <= 1'b0;
            txr_q <= 1'b0;
            rxd_q <= 8'h00;
            rxv_q <= 1'b0;
            rxe_q <= 1'b0;
            srqSent_q <= 1'b0;
        end else begin
            src_q <= src_d;
            acc_q <= acc_d;
            tads_q <= tads_d;
            lads_q <= lads_d;
            spms_q <= spms_d;
            rem_q <= rem_d;
            llo_q <= llo_d;
            rqs_q <= rqs_d;
            dout_q <= dout_d;
            eoi_q <= eoi_d;
            cnt_q <= cnt_d;
            trig_q <= trig_d;
            clr_q <= clr_d;
            txr_q <= txr_d;
            rxd_q <= rxd_d;
            rxv_q <= rxv_d;
            rxe_q <= rxe_d;
            srqSent_q <= srqSent_d;
        end
    end

    // Output pin enables, registered from the next-state values in step with the state.
    logic [7:0] dioOe_q;
    logic davOe_q, nrfdOe_q, ndacOe_q, srqOe_q, trigOut_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dioOe_q <= 8'h00;
            davOe_q <= 1'b0;
            nrfdOe_q <= 1'b0;
            ndacOe_q <= 1'b0;
            srqOe_q <= 1'b0;
            trigOut_q <= 1'b0;
        end else begin
            dioOe_q <= (src_d != SrcIdle) ? dout_d : 8'h00;
            davOe_q <= (src_d == SrcValid);
            nrfdOe_q <= (acc_d != AccReady) && (atn || lisAct);
            ndacOe_q <= (acc_d != AccDone) && (atn || lisAct);
            srqOe_q <= rqs_d;
            trigOut_q <= (trig_d != 16'h0000);
        end
    end

    assign dioOe = dioOe_q;
    assign davOe = davOe_q;
    assign nrfdOe = nrfdOe_q;
    assign ndacOe = ndacOe_q;
    assign eoiOe = eoi_q;
    assign srqOe = srqOe_q;
    assign trigOut = trigOut_q;
    assign txReady = txr_q;
    assign rxData = rxd_q;
    assign rxValid = rxv_q;
    assign rxEnd = rxe_q;
    assign devClear = clr_q;
    assign remote = rem_q;
    assign lockout = llo_q;
endmodule : ibi_device

// *** verification/ibi_device_asserts.sv ***
// Port checker for the instrument bus device end.
// Assumes one clock, clk_sys, and the asynchronous active-low resetn.
`timescale 1ns/1ns
module ibi_device_asserts #(
    parameter int TRIG_CYC = 50
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] dioOe,
    input wire logic davOe,
    input wire logic nrfdIn,
    input wire logic ndacIn,
    input wire logic ifcIn,
    input wire logic listenOnly,
    input wire logic talkOnly,
    input wire logic svcReq,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    input wire logic rxEnd,
    input wire logic devClear,
    input wire logic trigOut,
    input wire logic srqOe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Cycles the trigger output has stood high so far.
    int trigCnt_q;
    int trigCnt_d;
    // Grows while the trigger is high and clears once it drops.
    always_comb begin
        trigCnt_d = trigOut ? trigCnt_q + 1 : 0;
    end
    // Holds the count.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            trigCnt_q <= 0;
        end else begin
            trigCnt_q <= trigCnt_d;
        end
    end
    // Interface clear held long enough to cross the synchroniser.
    sequence ifcHeld;
        (!ifcIn) [*6];
    endsequence
    // The source starts a byte on the bus.
    sequence davStart;
        $rose(davOe);
    endsequence
    chk_trig_len: assert property
        ($fell(trigOut) |-> trigCnt_q == TRIG_CYC)
        else $error("trigger pulse has the wrong length");
    chk_rx_end: assert property
        (rxEnd |-> rxValid && rxData == 8'h0D)
        else $error("record end flagged on a byte other than CR");
    chk_rx_single: assert property
        (rxValid |=> !rxValid)
        else $error("two listen bytes from one handshake");
    chk_tx_take: assert property
        (txReady |-> $past(txValid) ##1 !txReady)
        else $error("talk byte taken without offer or twice");
    chk_dav_settle: assert property
        (davStart |-> dioOe == $past(dioOe, 2))
        else $error("data valid raised before data settled");
    chk_dav_ready: assert property
        (davStart |-> nrfdIn)
        else $error("data valid raised while listeners not ready");
    chk_dav_hold: assert property
        (davOe && !ndacIn && ifcIn |=> davOe)
        else $error("data valid dropped before acceptance");
    chk_ifc_idle: assert property
        (ifcHeld |-> !davOe && dioOe == 8'h00 && !txReady && !rxValid)
        else $error("talker or listener active during clear");
    chk_only_talk: assert property
        (listenOnly && !talkOnly |-> !davOe)
        else $error("listen-only device drives data valid");
    chk_srq_cause: assert property
        ($rose(srqOe) |-> svcReq)
        else $error("service request without instrument request");
    chk_clr_pulse: assert property
        (devClear |=> !devClear)
        else $error("device clear longer than one cycle");
endmodule : ibi_device_asserts

bind ibi_device ibi_device_asserts #(.TRIG_CYC(TRIG_CYC)) chk (
    .clk_sys, .resetn, .dioOe, .davOe, .nrfdIn, .ndacIn, .ifcIn,
    .listenOnly, .talkOnly, .svcReq, .txValid, .txReady, .rxData,
    .rxValid, .rxEnd, .devClear, .trigOut, .srqOe);

// *** verification/ibi_ctl_model.sv ***
// Bus controller model: sends commands and data, accepts talk bytes.
// Assumes pulled-up wired lines; an output high pulls its line low.
`timescale 1ns/1ns
module ibi_ctl_model (
    input wire logic clk_sys,
    input wire logic [7:0] dioLine,
    input wire logic davLine,
    input wire logic nrfdLine,
    input wire logic ndacLine,
    output logic [7:0] pDio,
    output logic pDav,
    output logic pNrfd,
    output logic pNdac,
    output logic pAtn,
    output logic pIfc,
    output int hangs
);
    // Handshake lines gathered for the bounded waits.
    wire logic [2:0] hsLine = {davLine, nrfdLine, ndacLine};
    // Everything released at start.
    initial begin
        {pDio, pDav, pNrfd, pNdac, pAtn, pIfc} = '0;
        hangs = 0;
    end
    // Waits at most 400 cycles for a handshake line level.
    task automatic waitLine(input int sel, input logic lvl);
        int n;
        n = 0;
        while (hsLine[sel] !== lvl && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        hangs += int'(n >= 400);
        #1;
    endtask : waitLine
    // Sources one byte; a command record goes out with attention set.
    task automatic send(input logic atn, input logic [7:0] b);
        @(posedge clk_sys);
        #1;
        {pNrfd, pNdac, pAtn, pDio} = {2'b00, atn, b};
        repeat (6) @(posedge clk_sys);
        waitLine(1, 1'b1);
        pDav = 1'b1;
        waitLine(0, 1'b1);
        pDav = 1'b0;
        pDio = 8'h00;
        repeat (8) @(posedge clk_sys);
        #1;
    endtask : send
    // Accepts one byte after gap cycles of holding not-ready.
    task automatic recv(output logic [7:0] b, input int gap);
        @(posedge clk_sys);
        #1;
        {pNrfd, pNdac, pAtn} = 3'b110;
        repeat (gap) @(posedge clk_sys);
        #1;
        pNrfd = 1'b0;
        waitLine(2, 1'b0);
        b = ~dioLine;
        {pNrfd, pNdac} = 2'b10;
        waitLine(2, 1'b1);
        pNdac = 1'b1;
    endtask : recv
    // Holds interface clear for ten cycles.
    task automatic clearBus();
        @(posedge clk_sys);
        #1;
        pIfc = 1'b1;
        repeat (10) @(posedge clk_sys);
        #1;
        pIfc = 1'b0;
    endtask : clearBus
endmodule : ibi_ctl_model

// *** verification/tb_top.sv ***
// Self-checking bench: instrument bus device facing a controller model.
// Assumes the design sources and the map header are compiled first.
`timescale 1ns/1ns
`include "ibi_map.svh"
module tb_top;
    import ibi_pkg::*;
    localparam int TRIG = 4;
    localparam logic [7:0] MLA = 8'h25;
    localparam logic [7:0] MTA = 8'h45;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic renIn = 1'b1;
    logic listenOnly = 1'b0;
    logic talkOnly = 1'b0;
    logic svcReq = 1'b0;
    logic [7:0] txData = 8'h00;
    logic txValid = 1'b0;
    logic [7:0] dioOe, pDio, rxData, got;
    logic davOe, nrfdOe, ndacOe, eoiOe, srqOe, pDav, pNrfd, pNdac, pAtn, pIfc;
    logic txReady, rxValid, rxEnd, devClear, trigOut, remote, lockout;
    int hangs, num_errors = 0, n_checks = 0, trigN = 0, clrN = 0, rdyN = 0;
    logic [8:0] rxQ[$];
    // Wired bus lines: low when any party pulls.
    wire logic [7:0] dioLn = ~(pDio | dioOe);
    wire logic davLn = ~(pDav | davOe);
    wire logic nrfdLn = ~(pNrfd | nrfdOe);
    wire logic ndacLn = ~(pNdac | ndacOe);
    always #10 clk_sys = ~clk_sys;
    ibi_device #(.TRIG_CYC(TRIG), .SETTLE_CYC(2)) uut (.clk_sys, .resetn,
        .dioIn(dioLn), .dioOe, .davIn(davLn), .davOe, .nrfdIn(nrfdLn),
        .nrfdOe, .ndacIn(ndacLn), .ndacOe, .atnIn(~pAtn), .ifcIn(~pIfc),
        .renIn, .eoiIn(~eoiOe), .eoiOe, .srqOe, .myAddr(5'h05), .listenOnly,
        .talkOnly, .svcReq, .statusByte(8'h81), .txData, .txValid, .txReady,
        .rxData, .rxValid, .rxEnd, .devClear, .trigOut, .remote, .lockout);
    ibi_ctl_model ctl (.clk_sys, .dioLine(dioLn), .davLine(davLn),
        .nrfdLine(nrfdLn), .ndacLine(ndacLn), .pDio, .pDav, .pNrfd, .pNdac,
        .pAtn, .pIfc, .hangs);
    // Collects listen bytes and counts trigger, clear and take cycles.
    always @(posedge clk_sys) begin
        if (rxValid === 1'b1) begin
            rxQ.push_back({rxEnd, rxData});
        end
        trigN += int'(trigOut === 1'b1);
        clrN += int'(devClear === 1'b1);
        rdyN += int'(txReady === 1'b1);
    end
    // Compares one value and reports a mismatch.
    task automatic chk(input string nm, input logic [8:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Instrument offers one byte while the controller accepts it.
    task automatic talk(input logic [7:0] b, input int gap);
        int n;
        n = 0;
        fork
            ctl.recv(got, gap);
            begin
                @(posedge clk_sys);
                #1;
                {txData, txValid} = {b, 1'b1};
                while (txReady !== 1'b1 && n < 300) begin
                    @(posedge clk_sys);
                    #1;
                    n++;
                end
                num_errors += int'(n >= 300);
                txValid = 1'b0;
            end
        join
        chk("talk byte", {1'b0, got}, {1'b0, b});
    endtask : talk
    // Talks every byte of a string.
    task automatic talkStr(input string s, input int gap);
        foreach (s[i]) talk(s[i], gap);
    endtask : talkStr
    // Listen record with CR LF, remote state, unlisten on own talk.
    task automatic t_listen();
        string s;
        s = "K1\015\012";
        renIn = 1'b0;
        rxQ.delete();
        ctl.send(1'b1, MLA);
        foreach (s[i]) ctl.send(1'b0, s[i]);
        foreach (s[i]) chk("listen", rxQ[i], {s[i] == 8'h0D, s[i]});
        chk("remote", {8'h00, remote}, 9'h001);
        ctl.send(1'b1, `IBI_CMD_LLO);
        chk("lockout", {8'h00, lockout}, 9'h001);
        ctl.send(1'b1, `IBI_CMD_GTL);
        chk("local", {8'h00, remote}, 9'h000);
        ctl.send(1'b1, MTA);
        rxQ.delete();
        ctl.send(1'b0, 8'h5A);
        chk("own talk unlistens", 9'(rxQ.size()), 9'h000);
        $display("t_listen done");
    endtask : t_listen
    // Trigger and clear only while listen addressed, universal clear always.
    task automatic t_trig();
        {trigN, clrN} = {32'd0, 32'd0};
        ctl.send(1'b1, MLA);
        ctl.send(1'b1, `IBI_CMD_GET);
        ctl.send(1'b1, `IBI_CMD_SDC);
        ctl.send(1'b1, 8'h3F);
        ctl.send(1'b1, `IBI_CMD_GET);
        ctl.send(1'b1, `IBI_CMD_SDC);
        ctl.send(1'b1, `IBI_CMD_DCL);
        chk("trigger cycles", 9'(trigN), 9'(TRIG));
        chk("clear pulses", 9'(clrN), 9'h002);
        $display("t_trig done");
    endtask : t_trig
    // Clear mid record idles both roles; the rest follows on re-address.
    task automatic t_ifc();
        ctl.send(1'b1, MTA);
        talkStr("S1\015", 0);
        talkStr("AB", 5);
        rdyN = 0;
        {txData, txValid} = {8'h43, 1'b1};
        repeat (12) @(posedge clk_sys);
        #1;
        chk("byte on lines", {1'b0, dioOe}, 9'h043);
        ctl.clearBus();
        ctl.send(1'b0, 8'h51);
        txValid = 1'b0;
        chk("talker idle", 9'(rdyN), 9'h000);
        ctl.send(1'b1, MLA);
        ctl.clearBus();
        rxQ.delete();
        ctl.send(1'b0, 8'h51);
        chk("listener idle", 9'(rxQ.size()), 9'h000);
        ctl.send(1'b1, MTA);
        talkStr("C\015", 0);
        $display("t_ifc done");
    endtask : t_ifc
    // Service request, serial poll byte, request cleared by the poll.
    task automatic t_srq();
        svcReq = 1'b1;
        ctl.send(1'b1, `IBI_CMD_SPE);
        chk("srq up", {8'h00, srqOe}, 9'h001);
        ctl.send(1'b1, MTA);
        ctl.recv(got, 3);
        chk("poll byte", {1'b0, got}, 9'h0C1);
        ctl.send(1'b1, `IBI_CMD_SPD);
        chk("srq down", {8'h00, srqOe}, 9'h000);
        svcReq = 1'b0;
        $display("t_srq done");
    endtask : t_srq
    // Listen-only and talk-only work without any addressing.
    task automatic t_only();
        ctl.clearBus();
        listenOnly = 1'b1;
        rxQ.delete();
        ctl.send(1'b0, 8'h4C);
        chk("listen only", rxQ[0], 9'h04C);
        {listenOnly, talkOnly} = 2'b01;
        talkStr("T\015", 2);
        talkOnly = 1'b0;
        $display("t_only done");
    endtask : t_only
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    // Cuts a hang short well beyond the expected run length.
    initial begin
        #600000;
        num_errors++;
        print_verdict();
    end
    // Reset for five cycles, then the scenarios in turn.
    initial begin
        repeat (5) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        t_listen();
        t_trig();
        t_ifc();
        t_srq();
        t_only();
        chk("bus waits", 9'(hangs), 9'h000);
        print_verdict();
    end
endmodule : tb_top
